/* pkg/lrmc_pkg.sv */
// Constants and types for the line rate and modem control block
package lrmc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int REF_CLK_HZ     = 50_000_000;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int XTAL_HZ        = 2_457_600;
  // Phase step per ref_clk for a 2^32 accumulator emulating the crystal
  localparam logic [31:0] XTAL_STEP =
    32'((64'(XTAL_HZ) << 32) / 64'(REF_CLK_HZ));
  localparam int DISC_PULSE_NS  = 700;
  // Longest time rounds down, at least one cycle
  localparam int DISC_CYCLES    = (DISC_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                  (DISC_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [5:0] DISC_CNT_INIT = 6'(DISC_CYCLES);

  // ****************************************
  // Rate selection
  // ****************************************
  localparam int NUM_BIN_RATES  = 7;
  // 16x clocks: 110 bps -> /1396 of the crystal, 1800 bps -> /85 (nearest)
  localparam logic [10:0] DIV_110  = 11'h574;
  localparam logic [10:0] DIV_1800 = 11'h055;
  // Codes 0..6: crystal / 2^(code+1) i.e. 76800..1200 bps; 7 = 110, 8 = 1800
  localparam logic [3:0] CODE_110  = 4'h7;
  localparam logic [3:0] CODE_1800 = 4'h8;
  localparam logic [3:0] BIT_DIV   = 4'hF;

  localparam logic [1:0] FUNC_W    = 2'h0;
  localparam logic [3:0] FUNC_DISCONNECT = 4'h9;

  typedef enum logic [1:0] {LRMC_TX_IDLE, LRMC_TX_DATA, LRMC_TX_STOP} lrmc_tx_state_t;

endpackage

/* pkg/lrmc_rate_if.sv */
// Interface carrying one direction's rate selection and 16x tick
interface lrmc_rate_if;
  logic [3:0] rate_code;
  logic       tick16;
  logic       valid_rate;
  modport gen (input rate_code, output tick16, output valid_rate);
  modport use_side (output rate_code, input tick16, input valid_rate);
endinterface

/* core/lrmc_rate_chain.sv */
// One divider chain with its sixteen-input rate selector
module lrmc_rate_chain (
  // Clock and reset
  input  wire logic    ref_clk,
  input  wire logic    sys_rst,
  // Crystal tick shared by both chains
  input  wire logic    xtal_tick,
  // Rate selection
  lrmc_rate_if.gen     rate
);

  // ****************************************
  // Binary chain and terminal-count counters
  // ****************************************
  logic [6:0]  bin_cnt;
  logic [10:0] cnt_110;
  logic [10:0] cnt_1800;
  logic [15:0] rate_tick;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bin_cnt <= 7'h00;
    end else if (xtal_tick) begin
      bin_cnt <= bin_cnt + 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_110  <= 11'h000;
      cnt_1800 <= 11'h000;
    end else if (xtal_tick) begin
      cnt_110  <= (cnt_110 == lrmc_pkg::DIV_110 - 11'h001) ? 11'h000 : cnt_110 + 11'h001;
      cnt_1800 <= (cnt_1800 == lrmc_pkg::DIV_1800 - 11'h001) ? 11'h000 :
                  cnt_1800 + 11'h001;
    end
  end

  // One-cycle ticks on the falling edge of each divided output (terminal count)
  genvar g;
  generate
    for (g = 0; g < lrmc_pkg::NUM_BIN_RATES; g++) begin : g_bin
      assign rate_tick[g] = xtal_tick && (bin_cnt[g:0] == {(g + 1){1'b1}});
    end
  endgenerate
  assign rate_tick[7]     = xtal_tick && (cnt_110 == lrmc_pkg::DIV_110 - 11'h001);
  assign rate_tick[8]     = xtal_tick && (cnt_1800 == lrmc_pkg::DIV_1800 - 11'h001);
  // Unused selector inputs carry no clock
  assign rate_tick[15:9]  = 7'h00;

  assign rate.tick16     = rate_tick[rate.rate_code];
  assign rate.valid_rate = (rate.rate_code <= lrmc_pkg::CODE_1800);

endmodule

/* core/lrmc_top.sv */
// Line rate generation, transmit framing and modem control
module lrmc_top (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Rate selection
  input  wire logic [3:0] tx_rate_code,
  input  wire logic [3:0] rx_rate_code,
  // Option switches
  input  wire logic       one_stop_sel,
  input  wire logic       two_stop_sel,
  input  wire logic       modem_path_select,
  input  wire logic       modem_path_select_n,
  // Transmit character
  input  wire logic       tx_load,
  input  wire logic [7:0] tx_char,
  output logic            tx_busy,
  output logic            tx_line,
  // Receive bit timing
  output logic            rx_bit_tick,
  // Modem lines
  input  wire logic       carrier_detect,
  output logic            terminal_ready,
  // Control functions
  input  wire logic       ctrl_strobe,
  input  wire logic [3:0] ctrl_func,
  // Status to host
  input  wire logic       status_read,
  output logic            carrier_irq,
  output logic            break_status_bit,
  output logic            input_flag_bit
);

  // ****************************************
  // Crystal reference
  // ****************************************
  // A phase accumulator stands in for the crystal so both chains share it
  logic [31:0] xtal_acc;
  logic        xtal_tick;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      xtal_acc  <= 32'h0000_0000;
      xtal_tick <= 1'b0;
    end else begin
      {xtal_tick, xtal_acc} <= {1'b0, xtal_acc} + {1'b0, lrmc_pkg::XTAL_STEP};
    end
  end

  // ****************************************
  // Divider chains
  // ****************************************
  lrmc_rate_if tx_rate ();
  lrmc_rate_if rx_rate ();
  assign tx_rate.rate_code = tx_rate_code;
  assign rx_rate.rate_code = rx_rate_code;

  lrmc_rate_chain u_tx_chain (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .xtal_tick (xtal_tick),
    .rate      (tx_rate.gen)
  );
  lrmc_rate_chain u_rx_chain (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .xtal_tick (xtal_tick),
    .rate      (rx_rate.gen)
  );

  // ****************************************
  // Divide by sixteen
  // ****************************************
  logic [3:0] tx_div;
  logic [3:0] rx_div;
  logic       tx_bit_tick;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_div      <= 4'h0;
      rx_div      <= 4'h0;
      tx_bit_tick <= 1'b0;
      rx_bit_tick <= 1'b0;
    end else begin
      tx_bit_tick <= tx_rate.tick16 && (tx_div == lrmc_pkg::BIT_DIV);
      rx_bit_tick <= rx_rate.tick16 && (rx_div == lrmc_pkg::BIT_DIV);
      if (tx_rate.tick16) begin
        tx_div <= tx_div + 4'h1;
      end
      if (rx_rate.tick16) begin
        rx_div <= rx_div + 4'h1;
      end
    end
  end

  // ****************************************
  // Transmitter framing
  // ****************************************
  lrmc_pkg::lrmc_tx_state_t tx_state;
  logic [8:0] tx_shift;
  logic [3:0] tx_count;
  logic       two_stop;
  // Switches are static, so sampling them at load is enough
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_state <= lrmc_pkg::LRMC_TX_IDLE;
      tx_shift <= 9'h1FF;
      tx_count <= 4'h0;
      tx_line  <= 1'b1;
      tx_busy  <= 1'b0;
      two_stop <= 1'b0;
    end else begin
      unique case (tx_state)
        lrmc_pkg::LRMC_TX_IDLE: begin
          tx_line <= 1'b1;
          if (tx_load && tx_rate.valid_rate) begin
            tx_shift <= {tx_char, 1'b0};
            tx_count <= 4'h9;
            two_stop <= two_stop_sel && !one_stop_sel;
            tx_busy  <= 1'b1;
            tx_state <= lrmc_pkg::LRMC_TX_DATA;
          end
        end
        lrmc_pkg::LRMC_TX_DATA: begin
          if (tx_bit_tick) begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[8:1]};
            tx_count <= tx_count - 4'h1;
            if (tx_count == 4'h1) begin
              tx_count <= two_stop ? 4'h2 : 4'h1;
              tx_state <= lrmc_pkg::LRMC_TX_STOP;
            end
          end
        end
        lrmc_pkg::LRMC_TX_STOP: begin
          if (tx_bit_tick) begin
            tx_line  <= 1'b1;
            tx_count <= tx_count - 4'h1;
            if (tx_count == 4'h0) begin
              tx_busy  <= 1'b0;
              tx_state <= lrmc_pkg::LRMC_TX_IDLE;
            end
          end
        end
        default: tx_state <= lrmc_pkg::LRMC_TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Carrier detect and status
  // ****************************************
  logic [2:0] cd_sync;
  logic       cd_state;
  logic       cd_change;
  logic       modem_mode;
  logic [1:0] cd_fill;
  logic       cd_armed;
  // Only a consistent switch pair counts as modem operation
  assign modem_mode = modem_path_select && !modem_path_select_n;
  // Until the synchroniser holds real samples the line level is taken
  // quietly, so a carrier already present at reset raises no interrupt
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cd_sync  <= 3'h0;
      cd_state <= 1'b0;
      cd_fill  <= 2'h0;
      cd_armed <= 1'b0;
    end else begin
      cd_sync  <= {cd_sync[1:0], carrier_detect};
      if (cd_fill != 2'h3) begin
        cd_fill <= cd_fill + 2'h1;
      end
      cd_armed <= (cd_fill == 2'h3);
      if (!cd_armed || cd_sync[2] == cd_sync[1]) begin
        cd_state <= cd_sync[2];
      end
    end
  end
  assign cd_change = cd_armed && (cd_sync[2] == cd_sync[1]) && (cd_sync[2] != cd_state);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      carrier_irq <= 1'b0;
    end else if (cd_change) begin
      carrier_irq <= 1'b1;
    end else if (status_read) begin
      carrier_irq <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      break_status_bit <= 1'b0;
      input_flag_bit   <= 1'b0;
    end else begin
      if (cd_change && modem_mode) begin
        break_status_bit <= !cd_sync[2];
        input_flag_bit   <= 1'b1;
      end else if (status_read) begin
        input_flag_bit <= 1'b0;
      end
    end
  end

  // ****************************************
  // Terminal ready and disconnect pulse
  // ****************************************
  logic [5:0] disc_cnt;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      disc_cnt       <= 6'h00;
      terminal_ready <= 1'b0;
    end else if (ctrl_strobe && ctrl_func == lrmc_pkg::FUNC_DISCONNECT) begin
      disc_cnt       <= lrmc_pkg::DISC_CNT_INIT;
      terminal_ready <= 1'b0;
    end else if (disc_cnt != 6'h00) begin
      disc_cnt       <= disc_cnt - 6'h01;
      terminal_ready <= (disc_cnt == 6'h01);
    end else begin
      terminal_ready <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Independent models for the checks below
  logic [5:0] chk_disc_age;
  logic [6:0] chk_xtal_cnt;
  logic [6:0] chk_pow_mask;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chk_disc_age <= 6'h3F;
    end else if (ctrl_strobe && ctrl_func == lrmc_pkg::FUNC_DISCONNECT) begin
      chk_disc_age <= 6'h01;
    end else if (chk_disc_age != 6'h3F) begin
      chk_disc_age <= chk_disc_age + 6'h01;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chk_xtal_cnt <= 7'h00;
    end else if (xtal_tick) begin
      chk_xtal_cnt <= chk_xtal_cnt + 7'h01;
    end
  end
  // Low bits that must all be set for a power-of-two code to tick
  assign chk_pow_mask = 7'((8'h02 << tx_rate_code) - 8'h01);
  a_disc_pulse_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (chk_disc_age <= lrmc_pkg::DISC_CNT_INIT) |-> !terminal_ready)
    else $error("disconnect pulse ended early");
  a_disc_pulse_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (chk_disc_age == lrmc_pkg::DISC_CNT_INIT + 6'h01) |-> terminal_ready)
    else $error("disconnect pulse ran too long");
  a_cd_irq_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cd_change |=> carrier_irq)
    else $error("carrier change gave no interrupt");
  a_cd_loss_break: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cd_change && modem_mode && !cd_sync[2]) |=> break_status_bit && input_flag_bit)
    else $error("carrier loss did not set break");
  a_cd_return_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (cd_change && modem_mode && cd_sync[2]) |=> !break_status_bit && input_flag_bit)
    else $error("carrier return did not clear break");
  a_bad_rate_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tx_rate_code > 4'h8) |-> !tx_rate.tick16)
    else $error("undefined rate code gave a clock");
  a_tx_div_sixteen: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(tx_bit_tick) |-> tx_div == 4'h0 && $past(tx_div) == lrmc_pkg::BIT_DIV)
    else $error("transmit divide by sixteen broken");
  a_stop_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tx_state == lrmc_pkg::LRMC_TX_STOP && tx_bit_tick) |=> tx_line)
    else $error("stop bit not high");
  a_xtal_spacing: assert property (@(posedge ref_clk) disable iff (sys_rst)
    xtal_tick |=> !xtal_tick [*8])
    else $error("reference tick too close");
  a_pow_two_rate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tx_rate_code < lrmc_pkg::CODE_110) |->
    (tx_rate.tick16 == (xtal_tick && ((chk_xtal_cnt & chk_pow_mask) == chk_pow_mask))))
    else $error("power-of-two rate tick misplaced");
  c_disconnect: cover property (@(posedge ref_clk) $fell(terminal_ready));
  c_cd_loss: cover property (@(posedge ref_clk) $rose(break_status_bit));
  c_two_stop: cover property (@(posedge ref_clk) tx_state == lrmc_pkg::LRMC_TX_STOP && two_stop);

endmodule

/* verification/lrmc_far_end.sv */
// Far-end terminal model: decodes the serial line and drives carrier detect
module lrmc_far_end #(
  parameter int BIT_CYCLES = 651
) (
  // Clock for sampling only, never sent back
  input  wire logic ref_clk,
  // Line from the device
  input  wire logic line_in,
  input  wire logic carrier_on,
  // Modem lines toward the device
  output logic      carrier_detect,
  // Decoded traffic
  output logic [7:0] got_char,
  output int         char_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // No transmit clock is ever offered, so the link stays full duplex
  initial begin
    int i;
    got_char = 8'h00;
    char_count = 0;
    forever begin
      @(negedge line_in);
      repeat (BIT_CYCLES / 2) @(posedge ref_clk);
      if (!line_in) begin
        for (i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge ref_clk);
          got_char[i] = line_in;
        end
        repeat (BIT_CYCLES) @(posedge ref_clk);
        if (line_in) char_count++;
      end
    end
  end
  // Pin is asynchronous to ref_clk, so change it off the clock
  initial begin
    carrier_detect = 1'b1;
    forever begin
      @(carrier_on);
      #7 carrier_detect = carrier_on;
    end
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the line rate and modem control block
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, sys_rst, one_stop_sel, two_stop_sel, tx_load, tx_busy, tx_line;
  logic       modem_path_select, modem_path_select_n, rx_bit_tick, carrier_detect;
  logic       terminal_ready, ctrl_strobe, status_read, carrier_irq, carrier_on;
  logic       break_status_bit, input_flag_bit;
  logic [3:0] tx_rate_code, rx_rate_code, ctrl_func;
  logic [7:0] tx_char, got_char;
  int         miscompares, tests_run, cyc, char_count;
  lrmc_top lrmc_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .tx_rate_code(tx_rate_code),
    .rx_rate_code(rx_rate_code), .one_stop_sel(one_stop_sel), .two_stop_sel(two_stop_sel),
    .modem_path_select(modem_path_select), .modem_path_select_n(modem_path_select_n),
    .tx_load(tx_load), .tx_char(tx_char), .tx_busy(tx_busy), .tx_line(tx_line),
    .rx_bit_tick(rx_bit_tick), .carrier_detect(carrier_detect),
    .terminal_ready(terminal_ready), .ctrl_strobe(ctrl_strobe), .ctrl_func(ctrl_func),
    .status_read(status_read), .carrier_irq(carrier_irq),
    .break_status_bit(break_status_bit), .input_flag_bit(input_flag_bit));
  lrmc_far_end lrmc_far_end_inst (.ref_clk(ref_clk), .line_in(tx_line),
    .carrier_on(carrier_on), .carrier_detect(carrier_detect), .got_char(got_char),
    .char_count(char_count));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task stop_test;
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, above the roughly 82k cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      stop_test();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  task t_idle;
    int n, ticks;
    @(negedge ref_clk);
    tx_rate_code = 4'h9;
    rx_rate_code = 4'hF;
    tx_load = 1'b1;
    @(negedge ref_clk);
    tx_load = 1'b0;
    ticks = 0;
    for (n = 0; n < 1500; n++) begin
      @(negedge ref_clk);
      ticks += rx_bit_tick;
    end
    `CHK("tx_busy_bad_rate", 1'b0, tx_busy)
    `CHK("rx_ticks_bad_rate", 0, ticks)
    tx_rate_code = 4'h0;
  endtask
  task t_tick(input logic [3:0] code, input int period);
    int n, t0;
    @(negedge ref_clk);
    rx_rate_code = code;
    for (n = 0; n < 30000 && !rx_bit_tick; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    t0 = cyc;
    for (n = 0; n < 30000 && !rx_bit_tick; n++) @(negedge ref_clk);
    `CHK("rx_tick_period", 1'b1, (cyc - t0 + 1 >= period - 2 && cyc - t0 + 1 <= period + 2))
  endtask
  task t_send(input logic [7:0] ch, input logic two, input int len);
    int n, t0, cnt0;
    @(negedge ref_clk);
    one_stop_sel = !two;
    two_stop_sel = two;
    cnt0 = char_count;
    tx_char = ch;
    tx_load = 1'b1;
    @(negedge ref_clk);
    tx_load = 1'b0;
    `CHK("tx_busy_after_load", 1'b1, tx_busy)
    for (n = 0; n < 2000 && tx_line; n++) @(negedge ref_clk);
    t0 = cyc;
    // A load while busy must be ignored
    tx_char = ~ch;
    tx_load = 1'b1;
    @(negedge ref_clk);
    tx_load = 1'b0;
    for (n = 0; n < 9000 && tx_busy; n++) @(negedge ref_clk);
    `CHK("frame_length", 1'b1, (cyc - t0 >= len - 5 && cyc - t0 <= len + 25))
    `CHK("received_char", ch, got_char)
    `CHK("char_count", cnt0 + 1, char_count)
  endtask
  task t_disc;
    int n, low;
    @(negedge ref_clk);
    ctrl_func = 4'h8;
    ctrl_strobe = 1'b1;
    @(negedge ref_clk);
    `CHK("ready_other_func", 1'b1, terminal_ready)
    ctrl_func = 4'h9;
    @(negedge ref_clk);
    ctrl_strobe = 1'b0;
    low = 0;
    for (n = 0; n < 100 && !terminal_ready; n++) begin
      low++;
      @(negedge ref_clk);
    end
    `CHK("ready_low_cycles", 700 / 20, low)
  endtask
  task t_carrier(input logic modem, input logic on, input logic brk, input logic flag);
    @(negedge ref_clk);
    status_read = 1'b1;
    @(negedge ref_clk);
    status_read = 1'b0;
    modem_path_select = modem;
    modem_path_select_n = !modem;
    carrier_on = on;
    repeat (12) @(negedge ref_clk);
    `CHK("carrier_irq", 1'b1, carrier_irq)
    `CHK("break_status_bit", brk, break_status_bit)
    `CHK("input_flag_bit", flag, input_flag_bit)
  endtask
  initial begin
    {tx_rate_code, rx_rate_code, ctrl_func, tx_char} = '0;
    {tx_load, ctrl_strobe, status_read, two_stop_sel, modem_path_select} = '0;
    {one_stop_sel, modem_path_select_n, carrier_on, sys_rst} = '1;
    repeat (8) @(negedge ref_clk);
    `CHK("tx_line_reset", 1'b1, tx_line)
    sys_rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK("ready_after_reset", 1'b1, terminal_ready)
    `CHK("irq_after_reset", 1'b0, carrier_irq)
    t_idle();
    t_tick(4'h0, 651);
    t_tick(4'h1, 1302);
    t_tick(4'h2, 2604);
    t_tick(4'h8, 27669);
    t_send(8'hA5, 1'b0, 6510);
    t_send(8'h3C, 1'b1, 7161);
    t_disc();
    t_carrier(1'b1, 1'b0, 1'b1, 1'b1);
    t_carrier(1'b1, 1'b1, 1'b0, 1'b1);
    t_carrier(1'b0, 1'b0, 1'b0, 1'b0);
    stop_test();
  end
endmodule
